// ===== dcbf_pkg.sv
// shared constants and pin bundles for the bidirectional queue controller
package dcbf_pkg;
    localparam int DATA_W        = 36;
    localparam int QUEUE_DEPTH   = 64;
    localparam int PTR_W         = 7;
    localparam int CLK_PERIOD_NS = 50;
    // port-clock edges a flag needs before it reflects a new fill level
    localparam int SYNC_EDGES    = 2;
    localparam logic [PTR_W-1:0] FULL_FILL = PTR_W'(QUEUE_DEPTH);

    // threshold offsets picked by the two select pins at reset release; OFS_RST is the system-reset value
    localparam logic [4:0] OFS_LL  = 5'h04;
    localparam logic [4:0] OFS_LH  = 5'h08;
    localparam logic [4:0] OFS_HL  = 5'h0C;
    localparam logic [4:0] OFS_HH  = 5'h10;
    localparam logic [4:0] OFS_RST = 5'h04;

    // port b width select codes {high, low}
    localparam logic [1:0] WSEL_LONG = 2'h0;
    localparam logic [1:0] WSEL_WORD = 2'h1;
    localparam logic [1:0] WSEL_BYTE = 2'h2;
    localparam logic [1:0] WSEL_MAIL = 2'h3;
    // index of the last part of a long word per width
    localparam logic [1:0] LAST_LONG = 2'h0;
    localparam logic [1:0] LAST_WORD = 2'h1;
    localparam logic [1:0] LAST_BYTE = 2'h3;

    typedef struct packed {
        logic              clk;
        logic              sel_n;
        logic              dir;
        logic              en;
        logic              mail;
        logic [DATA_W-1:0] data;
    } dcbf_pa_t;

    typedef struct packed {
        logic              clk;
        logic              sel_n;
        logic              dir;
        logic              en;
        logic [1:0]        wsel;
        logic [DATA_W-1:0] data;
    } dcbf_pb_t;

    typedef struct packed {
        logic       rst_n;
        logic [1:0] tsel;
    } dcbf_glb_t;

    localparam dcbf_pa_t PA_IDLE = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 36'h0};
    localparam dcbf_pb_t PB_IDLE = '{1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 36'h0};
    localparam dcbf_glb_t GLB_IDLE = '{1'b0, 2'h0};
endpackage : dcbf_pkg

// ===== dcbf_fifo.sv
// flip-flop queue with valid/ready on both sides and exposed pointers
`timescale 1ns/1ps
module dcbf_fifo #(
    parameter int  WIDTH = 36,
    parameter int  DEPTH = 64,
    localparam int AW    = $clog2(DEPTH)
) (
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_ce,
    input  wire logic             i_clear,
    input  wire logic             i_push_valid,
    output logic                  o_push_ready,
    input  wire logic [WIDTH-1:0] i_push_data,
    output logic                  o_pop_valid,
    input  wire logic             i_pop_ready,
    output logic      [WIDTH-1:0] o_pop_data,
    output logic      [AW:0]      o_wr_ptr,
    output logic      [AW:0]      o_rd_ptr
);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic [AW:0]      fill;
    logic             push;
    logic             pop;

    // extra wrap bit tells full from empty with equal indices
    assign fill         = wr_q - rd_q;
    assign o_push_ready = fill != FULL_CNT;
    assign o_pop_valid  = fill != '0;
    assign push         = i_push_valid & o_push_ready;
    assign pop          = i_pop_ready & o_pop_valid;
    assign o_pop_data   = mem_q[rd_q[AW-1:0]];
    assign o_wr_ptr     = wr_q;
    assign o_rd_ptr     = rd_q;

    // pointers wrap around the array
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || (i_ce && i_clear)) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (i_ce) begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end

    // one write port per entry; storage needs no reset
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge i_mclk) begin
            if (i_ce && push && !i_clear && wr_q[AW-1:0] == AW'(g)) begin
                mem_q[g] <= i_push_data;
            end
        end
    end
endmodule : dcbf_fifo

// ===== dcbf_top.sv
// two opposite queues with synchronized flags and two mail registers
`timescale 1ns/1ps
module dcbf_top
    import dcbf_pkg::*;
#(
    parameter int Q_DEPTH = QUEUE_DEPTH
) (
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_ce,
    input  wire logic              i_dev_reset_n,
    input  wire logic              i_threshold_select_low,
    input  wire logic              i_threshold_select_high,
    input  wire logic              i_clock_porta,
    input  wire logic              i_select_n_porta,
    input  wire logic              i_direction_porta,
    input  wire logic              i_enable_porta,
    input  wire logic              i_mail_select_porta,
    input  wire logic [DATA_W-1:0] i_data_porta,
    output logic      [DATA_W-1:0] o_data_porta,
    output logic                   o_data_porta_oe,
    output logic                   o_empty_flag_porta,
    output logic                   o_full_flag_porta,
    output logic                   o_near_empty_flag_porta,
    output logic                   o_near_full_flag_porta,
    input  wire logic              i_clock_portb,
    input  wire logic              i_select_n_portb,
    input  wire logic              i_direction_portb,
    input  wire logic              i_enable_portb,
    input  wire logic              i_width_select_low,
    input  wire logic              i_width_select_high,
    input  wire logic [DATA_W-1:0] i_data_portb,
    output logic      [DATA_W-1:0] o_data_portb,
    output logic                   o_data_portb_oe,
    output logic                   o_empty_flag_portb,
    output logic                   o_full_flag_portb,
    output logic                   o_near_empty_flag_portb,
    output logic                   o_near_full_flag_portb,
    output logic                   o_mail_one_flag_n,
    output logic                   o_mail_two_flag_n
);
    dcbf_pa_t          pa_pin, pa_s1_q, pa;
    dcbf_pb_t          pb_pin, pb_s1_q, pb;
    dcbf_glb_t         glb_pin, glb_s1_q, glb;
    logic              pa_clk_prev_q, pb_clk_prev_q, rst_n_prev_q;
    logic              ea, eb, dev_rst, rst_rise;
    logic [4:0]        x_q, x_pick;
    logic [PTR_W-1:0]  ab_wr, ab_rd, ba_wr, ba_rd;
    logic [PTR_W-1:0]  abw_s1_q, abw_s2_q, abr_s1_q, abr_s2_q;
    logic [PTR_W-1:0]  baw_s1_q, baw_s2_q, bar_s1_q, bar_s2_q;
    logic [PTR_W-1:0]  ab_fill_wr, ab_fill_rd, ba_fill_wr, ba_fill_rd;
    logic [PTR_W-1:0]  af_thr, x_wide;
    logic [1:0]        ffa_rdy_q, ffb_rdy_q, part_q, part_last;
    logic              ab_ready, ab_valid, ba_ready, ba_valid;
    logic [DATA_W-1:0] ab_data, ba_data;
    logic [DATA_W-1:0] out_ab_q, out_ba_q, mail1_q, mail2_q;
    logic              mail1_n_q, mail2_n_q;
    logic              a_act, a_wr_q, a_wr_mail, a_rd_q, a_rd_mail;
    logic              b_act, b_mail, b_wr_q, b_wr_mail, b_rd_q, b_rd_mail;
    logic              push_ab, pop_ab, push_ba, pop_ba;

    // pins gathered so data and controls share the same two stages
    assign pa_pin  = '{i_clock_porta, i_select_n_porta, i_direction_porta,
                       i_enable_porta, i_mail_select_porta, i_data_porta};
    assign pb_pin  = '{i_clock_portb, i_select_n_portb, i_direction_portb,
                       i_enable_portb,
                       {i_width_select_high, i_width_select_low},
                       i_data_portb};
    assign glb_pin = '{i_dev_reset_n,
                       {i_threshold_select_high, i_threshold_select_low}};

    // two-stage synchronizers; only the second stage feeds logic
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pa_s1_q  <= PA_IDLE;
            pa       <= PA_IDLE;
            pb_s1_q  <= PB_IDLE;
            pb       <= PB_IDLE;
            glb_s1_q <= GLB_IDLE;
            glb      <= GLB_IDLE;
        end else if (i_ce) begin
            pa_s1_q  <= pa_pin;
            pa       <= pa_s1_q;
            pb_s1_q  <= pb_pin;
            pb       <= pb_s1_q;
            glb_s1_q <= glb_pin;
            glb      <= glb_s1_q;
        end
    end

    // edge history of the synchronized port clocks and device reset
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pa_clk_prev_q <= 1'b0;
            pb_clk_prev_q <= 1'b0;
            rst_n_prev_q  <= 1'b0;
        end else if (i_ce) begin
            pa_clk_prev_q <= pa.clk;
            pb_clk_prev_q <= pb.clk;
            rst_n_prev_q  <= glb.rst_n;
        end
    end

    // port clocks are sampled, so each must stay below half the mclk rate
    assign ea       = pa.clk & ~pa_clk_prev_q;
    assign eb       = pb.clk & ~pb_clk_prev_q;
    assign dev_rst  = ~glb.rst_n;
    assign rst_rise = glb.rst_n & ~rst_n_prev_q;

    // offset preset table
    assign x_pick = (glb.tsel == 2'h3) ? OFS_HH :
                    (glb.tsel == 2'h2) ? OFS_HL :
                    (glb.tsel == 2'h1) ? OFS_LH : OFS_LL;
    assign x_wide = {2'h0, x_q};
    assign af_thr = FULL_FILL - x_wide;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            x_q <= OFS_RST;
        end else if (i_ce && rst_rise) begin
            x_q <= x_pick;
        end
    end

    // port a decode
    assign a_act     = ea & ~pa.sel_n & pa.en & ~dev_rst;
    assign a_wr_q    = a_act & pa.dir & ~pa.mail;
    assign a_wr_mail = a_act & pa.dir & pa.mail & mail1_n_q;
    assign a_rd_q    = a_act & ~pa.dir & ~pa.mail
                       & o_empty_flag_porta;
    assign a_rd_mail = a_act & ~pa.dir & pa.mail;
    assign push_ab   = a_wr_q & o_full_flag_porta & ab_ready;
    assign pop_ba    = a_rd_q & ba_valid;

    // port b decode; both width selects high means mail access
    assign b_mail    = pb.wsel == WSEL_MAIL;
    assign b_act     = eb & ~pb.sel_n & pb.en & ~dev_rst;
    assign b_wr_q    = b_act & pb.dir & ~b_mail;
    assign b_wr_mail = b_act & pb.dir & b_mail & mail2_n_q;
    assign b_rd_q    = b_act & ~pb.dir & ~b_mail
                       & o_empty_flag_portb;
    assign b_rd_mail = b_act & ~pb.dir & b_mail;
    assign push_ba   = b_wr_q & o_full_flag_portb & ba_ready;
    // a new long word enters the output register only on its first part
    assign pop_ab    = b_rd_q & (part_q == 2'h0) & ab_valid;

    // narrow reads walk the parts of one long word
    assign part_last = (pb.wsel == WSEL_WORD) ? LAST_WORD :
                       (pb.wsel == WSEL_BYTE) ? LAST_BYTE : LAST_LONG;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            part_q <= 2'h0;
        end else if (i_ce) begin
            if (dev_rst) part_q <= 2'h0;
            else if (b_rd_q) part_q <= (part_q >= part_last) ? 2'h0
                                        : part_q + 2'h1;
        end
    end

    dcbf_fifo #(.WIDTH(DATA_W), .DEPTH(Q_DEPTH)) u_queue_a_to_b (
        .i_mclk       (i_mclk),
        .i_sys_rst    (i_sys_rst),
        .i_ce         (i_ce),
        .i_clear      (dev_rst),
        .i_push_valid (a_wr_q & o_full_flag_porta),
        .o_push_ready (ab_ready),
        .i_push_data  (pa.data),
        .o_pop_valid  (ab_valid),
        .i_pop_ready  (pop_ab),
        .o_pop_data   (ab_data),
        .o_wr_ptr     (ab_wr),
        .o_rd_ptr     (ab_rd)
    );

    dcbf_fifo #(.WIDTH(DATA_W), .DEPTH(Q_DEPTH)) u_queue_b_to_a (
        .i_mclk       (i_mclk),
        .i_sys_rst    (i_sys_rst),
        .i_ce         (i_ce),
        .i_clear      (dev_rst),
        .i_push_valid (b_wr_q & o_full_flag_portb),
        .o_push_ready (ba_ready),
        .i_push_data  (pb.data),
        .o_pop_valid  (ba_valid),
        .i_pop_ready  (pop_ba),
        .o_pop_data   (ba_data),
        .o_wr_ptr     (ba_wr),
        .o_rd_ptr     (ba_rd)
    );

    // pointer views move only on the observing port's edges, two deep;
    // an edge in the same cycle as the update still samples the old value
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || (i_ce && dev_rst)) begin
            abw_s1_q <= '0;
            abw_s2_q <= '0;
            bar_s1_q <= '0;
            bar_s2_q <= '0;
            abr_s1_q <= '0;
            abr_s2_q <= '0;
            baw_s1_q <= '0;
            baw_s2_q <= '0;
        end else if (i_ce) begin
            if (eb) begin
                abw_s1_q <= ab_wr;
                abw_s2_q <= abw_s1_q;
                bar_s1_q <= ba_rd;
                bar_s2_q <= bar_s1_q;
            end
            if (ea) begin
                abr_s1_q <= ab_rd;
                abr_s2_q <= abr_s1_q;
                baw_s1_q <= ba_wr;
                baw_s2_q <= baw_s1_q;
            end
        end
    end

    // full flags stay low for two writer edges after reset release
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || (i_ce && dev_rst)) begin
            ffa_rdy_q <= 2'h0;
            ffb_rdy_q <= 2'h0;
        end else if (i_ce) begin
            if (ea) ffa_rdy_q <= {ffa_rdy_q[0], 1'b1};
            if (eb) ffb_rdy_q <= {ffb_rdy_q[0], 1'b1};
        end
    end

    // fill as seen by each side: true own pointer, delayed far pointer
    assign ab_fill_rd = abw_s2_q - ab_rd;
    assign ab_fill_wr = ab_wr - abr_s2_q;
    assign ba_fill_rd = baw_s2_q - ba_rd;
    assign ba_fill_wr = ba_wr - bar_s2_q;

    assign o_empty_flag_portb      = (ab_fill_rd != '0)
                                     | (part_q != 2'h0);
    assign o_near_empty_flag_portb = ab_fill_rd > x_wide;
    assign o_full_flag_porta       = ffa_rdy_q[1]
                                     & (ab_fill_wr != FULL_FILL);
    assign o_near_full_flag_porta  = ab_fill_wr < af_thr;
    assign o_empty_flag_porta      = ba_fill_rd != '0;
    assign o_near_empty_flag_porta = ba_fill_rd > x_wide;
    assign o_full_flag_portb       = ffb_rdy_q[1]
                                     & (ba_fill_wr != FULL_FILL);
    assign o_near_full_flag_portb  = ba_fill_wr < af_thr;

    // output registers load on each queue pop; a narrow port b read loads only on the first part
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            out_ab_q <= '0;
            out_ba_q <= '0;
        end else if (i_ce) begin
            if (pop_ab) out_ab_q <= ab_data;
            if (pop_ba) out_ba_q <= ba_data;
        end
    end

    // mail registers; a write wins over a same-cycle read of the flag
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mail1_q   <= '0;
            mail2_q   <= '0;
            mail1_n_q <= 1'b1;
            mail2_n_q <= 1'b1;
        end else if (i_ce) begin
            if (a_wr_mail) mail1_q <= pa.data;
            if (b_wr_mail) mail2_q <= pb.data;
            if (dev_rst) mail1_n_q <= 1'b1;
            else if (a_wr_mail) mail1_n_q <= 1'b0;
            else if (b_rd_mail) mail1_n_q <= 1'b1;
            if (dev_rst) mail2_n_q <= 1'b1;
            else if (b_wr_mail) mail2_n_q <= 1'b0;
            else if (a_rd_mail) mail2_n_q <= 1'b1;
        end
    end

    assign o_mail_one_flag_n = mail1_n_q;
    assign o_mail_two_flag_n = mail2_n_q;

    // data drive follows select and direction even without enable
    assign o_data_porta_oe = ~pa.sel_n & ~pa.dir;
    assign o_data_porta    = pa.mail ? mail2_q : out_ba_q;
    assign o_data_portb_oe = ~pb.sel_n & ~pb.dir;
    assign o_data_portb    = b_mail ? mail1_q : out_ab_q;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    ab_pop_guard_a: assert property (
        pop_ab |-> abw_s2_q != ab_rd)
        else $error("queue a-to-b read while empty view");
    ab_push_guard_a: assert property (
        push_ab |-> (ab_wr - ab_rd) != FULL_FILL)
        else $error("queue a-to-b write while full");
    ab_wr_step_a: assert property (
        push_ab && i_ce |=> ab_wr == $past(ab_wr) + 7'h01)
        else $error("write pointer did not step");
    ab_rd_step_a: assert property (
        pop_ab && i_ce |=> ab_rd == $past(ab_rd) + 7'h01
        && out_ab_q == $past(ab_data))
        else $error("read pointer or output register wrong");
    // only a fully settled empty view; a word half way through the
    // stages may legally raise the flag on the next reader edge
    empty_lag_a: assert property (
        push_ab && i_ce && !o_empty_flag_portb
        && abw_s1_q == ab_wr && abw_s2_q == ab_wr |=> !o_empty_flag_portb)
        else $error("empty flag rose too early");
    mail_hold_a: assert property (
        !mail1_n_q && i_ce |=> mail1_q == $past(mail1_q))
        else $error("mail one changed while flag low");
    mail_clear_a: assert property (
        a_wr_mail && i_ce |=> !o_mail_one_flag_n
        && mail1_q == $past(pa.data))
        else $error("mail one write not taken");
    mail_read_a: assert property (
        a_rd_mail && !b_wr_mail && !dev_rst && i_ce |=> o_mail_two_flag_n)
        else $error("mail two read did not set flag");
    reset_flags_a: assert property (
        dev_rst && i_ce |=> !o_full_flag_porta && !o_empty_flag_porta
        && !o_near_empty_flag_porta && o_near_full_flag_porta
        && o_mail_one_flag_n)
        else $error("flags wrong after device reset");
    offset_pick_a: assert property (
        rst_rise && i_ce && glb.tsel == 2'h3 |=> x_q == OFS_HH)
        else $error("offset not latched at reset release");

    ab_fill_c: cover property (push_ab && (ab_wr - ab_rd) == 7'h3F);
    mail_trip_c: cover property (b_rd_mail && !o_mail_one_flag_n);
    byte_read_c: cover property (pop_ab && pb.wsel == WSEL_BYTE);
    ba_read_c: cover property (pop_ba);
endmodule : dcbf_top

// ===== dcbf_host_model.sv
// free-running port clock of the host sitting on one side of the queues
`timescale 1ns/1ps
module dcbf_host_model #(
    parameter int HALF = 4
) (
    input  wire logic i_mclk,
    output logic      o_clk
);
    int   cnt_q = 0;
    logic clk_q = 1'b0;

    // toggles on falling mclk so port pins never move on the sampling edge;
    // the clock runs free, so both ports see edges through device reset
    always @(negedge i_mclk) begin
        if (cnt_q == HALF - 1) begin
            cnt_q = 0;
            clk_q = ~clk_q;
        end else begin
            cnt_q++;
        end
    end

    // one driver for the port clock pin
    assign o_clk = clk_q;
endmodule : dcbf_host_model

// ===== dcbf_top_test.sv
// self-checking bench for the bidirectional queue and mailbox controller
`timescale 1ns/1ps
module dcbf_top_test;
    import dcbf_pkg::*;
    localparam int LIMIT = 40000;
    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        rst_n = 1'b0;
    logic [1:0]  tsel = 2'h0;
    dcbf_pa_t    pa = PA_IDLE;
    dcbf_pb_t    pb = PB_IDLE;
    wire logic   clk_a;
    wire logic   clk_b;
    logic [35:0] da;
    logic [35:0] db;
    logic        oea, oeb, efa, ffa, aea, afa, efb, ffb, aeb, afb, mf1, mf2;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          xs [4] = '{4, 8, 12, 16};

    always #25 i_mclk = ~i_mclk;

    // port a host faster than port b host, unrelated edge spacing
    dcbf_host_model #(.HALF(4)) dcbf_host_model_i (
        .i_mclk(i_mclk), .o_clk(clk_a));
    dcbf_host_model #(.HALF(5)) dcbf_host_model_b_i (
        .i_mclk(i_mclk), .o_clk(clk_b));

    dcbf_top dcbf_top_i (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
        .i_dev_reset_n(rst_n), .i_threshold_select_low(tsel[0]),
        .i_threshold_select_high(tsel[1]), .i_clock_porta(clk_a),
        .i_select_n_porta(pa.sel_n), .i_direction_porta(pa.dir),
        .i_enable_porta(pa.en), .i_mail_select_porta(pa.mail),
        .i_data_porta(pa.data), .o_data_porta(da), .o_data_porta_oe(oea),
        .o_empty_flag_porta(efa), .o_full_flag_porta(ffa),
        .o_near_empty_flag_porta(aea), .o_near_full_flag_porta(afa),
        .i_clock_portb(clk_b), .i_select_n_portb(pb.sel_n),
        .i_direction_portb(pb.dir), .i_enable_portb(pb.en),
        .i_width_select_low(pb.wsel[0]), .i_width_select_high(pb.wsel[1]),
        .i_data_portb(pb.data), .o_data_portb(db), .o_data_portb_oe(oeb),
        .o_empty_flag_portb(efb), .o_full_flag_portb(ffb),
        .o_near_empty_flag_portb(aeb), .o_near_full_flag_portb(afb),
        .o_mail_one_flag_n(mf1), .o_mail_two_flag_n(mf2));

    task automatic chk(input string nm, input logic [35:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // one enabled port edge; select stays low so read data stays visible
    task automatic pa_op(input logic d, m, input logic [35:0] v);
        @(negedge clk_a);
        pa = '{1'b0, 1'b0, d, 1'b1, m, v};
        @(negedge clk_a);
        pa.en = 1'b0;
        repeat (4) @(negedge i_mclk);
    endtask : pa_op

    task automatic pb_op(input logic d, input logic [1:0] w,
                         input logic [35:0] v);
        @(negedge clk_b);
        pb = '{1'b0, 1'b0, d, 1'b1, w, v};
        @(negedge clk_b);
        pb.en = 1'b0;
        repeat (4) @(negedge i_mclk);
    endtask : pb_op

    // enough observer edges for every flag to catch up with the fill
    task automatic settle;
        repeat (3) @(negedge clk_b);
        repeat (3) @(negedge clk_a);
    endtask : settle

    // reset held over more than four edges of the slower port clock
    task automatic dev_rst(input logic [1:0] t);
        @(negedge i_mclk);
        rst_n = 1'b0;
        tsel = t;
        repeat (6) @(negedge clk_b);
        chk("rst_full", {ffa, ffb, afa}, 3'h1);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_b);
        chk("rst_flags", {efa, efb, aea, aeb, afa, afb, ffa, ffb, mf1, mf2},
            10'h03F);
    endtask : dev_rst

    // hang guard: a run that overstays counts as a mismatch
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        for (int t = 0; t < 4; t++) begin
            dev_rst(t[1:0]);
            for (int i = 0; i <= xs[t]; i++) begin
                if (i == xs[t]) settle();
                if (i == xs[t]) chk("aeb_at_x", aeb, 1'b0);
                // offset data so a stale entry differs from the reset value
                pa_op(1'b1, 1'b0, 36'h100 + 36'(i));
            end
            chk("aeb_early", aeb, 1'b0);
            settle();
            chk("aeb_above_x", aeb, 1'b1);
        end
        $display("threshold test done");
        dev_rst(2'h0);
        pb_op(1'b0, WSEL_LONG, 36'h0);
        chk("empty_read", db, 36'h0);
        pa_op(1'b1, 1'b0, 36'h0);
        chk("efb_early", efb, 1'b0);
        for (int i = 1; i < 64; i++) pa_op(1'b1, 1'b0, 36'(i));
        pa_op(1'b1, 1'b0, 36'hABC);
        settle();
        chk("full_flags", {efb, ffa, afa}, 3'h4);
        for (int i = 0; i < 64; i++) begin
            pb_op(1'b0, WSEL_LONG, 36'h0);
            chk("q_ab_data", db, 36'(i));
            if (i == 0) chk("ffa_early", ffa, 1'b0);
            if (i == 0 || i == 4) settle();
            if (i == 0 || i == 4) chk("ffa_free", ffa, 1'b1);
            if (i == 0 || i == 4) chk("afa_fill", afa, 36'(i == 4));
        end
        settle();
        chk("efb_drained", efb, 1'b0);
        pb_op(1'b0, WSEL_LONG, 36'h0);
        chk("ignored_read", db, 36'h3F);
        $display("full and empty test done");
        for (int w = 1; w < 3; w++) begin
            pa_op(1'b1, 1'b0, 36'h5A5);
            settle();
            for (int k = 0; k < 2 * w; k++) begin
                pb_op(1'b0, w[1:0], 36'h0);
                settle();
                chk("efb_part", efb, 36'(k < 2 * w - 1));
            end
            chk("part_data", db, 36'h5A5);
        end
        $display("part read test done");
        pa_op(1'b1, 1'b1, 36'h123456789);
        chk("mail1_flag", mf1, 1'b0);
        pa_op(1'b1, 1'b1, 36'h0FF);
        pb_op(1'b0, WSEL_MAIL, 36'h0);
        chk("mail1_data", db, 36'h123456789);
        chk("mail1_read", {mf1, oeb}, 2'h3);
        pb_op(1'b1, WSEL_MAIL, 36'hCAFE);
        chk("mail2_flag", mf2, 1'b0);
        pa_op(1'b0, 1'b1, 36'h0);
        chk("mail2_data", da, 36'hCAFE);
        chk("mail2_read", {mf2, oea}, 2'h3);
        pb_op(1'b1, WSEL_LONG, 36'h777);
        settle();
        chk("efa_data", efa, 1'b1);
        pa_op(1'b0, 1'b0, 36'h0);
        chk("q_ba_data", da, 36'h777);
        settle();
        chk("efa_drained", efa, 1'b0);
        $display("mailbox test done");
        end_of_test();
    end
endmodule : dcbf_top_test
